// [design/svrc_boost_timer.sv]
`timescale 1ns/1ps
module svrc_boost_timer
  import svrc_pkg::*;
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               rst_n_in,
  // Control
  input  wire logic               start_in,
  input  wire logic [BOOST_W-1:0] duration_in,
  // Status
  output logic                    boost_active_out
);
  typedef struct packed {
    logic [BOOST_W-1:0] count;
    logic               active;
  } svrc_bt_state_t;

  svrc_bt_state_t st_r;
  svrc_bt_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (start_in) begin
      st_nxt.count  = duration_in;
      st_nxt.active = (duration_in != '0);
    end else if (st_r.active) begin
      st_nxt.count = st_r.count - 1'b1;
      if (st_r.count == {{(BOOST_W-1){1'b0}}, 1'b1}) begin
        st_nxt.active = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign boost_active_out = st_r.active;

  a_boost_len: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (start_in && duration_in == 16'h0006) |=> boost_active_out [*6] ##1 !boost_active_out)
    else $error("boost phase length wrong");
endmodule // svrc_boost_timer

// [design/svrc_ctrl.sv]
`timescale 1ns/1ps
module svrc_ctrl
  import svrc_pkg::*;
(
  // Clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    arst_n_in,
  // Frequency sets
  input  wire logic                    freq_a_we_in,
  input  wire logic                    freq_b_we_in,
  input  wire logic [FREQ_W-1:0]       freq_wdata_in,
  output logic      [FREQ_W-1:0]       carrier_freq_set_a_out,
  output logic      [FREQ_W-1:0]       carrier_freq_set_b_out,
  // VCO divider configuration
  input  wire logic                    vco_div_we_in,
  input  wire logic                    output_divider_bit_in,
  input  wire logic                    inductor_select_bit_in,
  input  wire logic                    vco_select_bit_in,
  input  wire logic [REFERENCE_DIVIDER_FIELD_W-1:0]     reference_divider_field_in,
  output logic                         output_divider_bit_out,
  output logic      [REFERENCE_DIVIDER_FIELD_W-1:0]     reference_divider_field_out,
  output logic      [VSEL_W-1:0]       vco_mode_out,
  // Loop filter and charge pump
  input  wire logic                    loop_we_in,
  input  wire logic [FLT_W-1:0]        loop_filter_normal_in,
  input  wire logic [FLT_W-1:0]        loop_filter_boost_in,
  input  wire logic [CPI_W-1:0]        charge_pump_normal_in,
  input  wire logic [CPI_W-1:0]        charge_pump_boost_in,
  input  wire logic [BOOST_W-1:0]      boost_duration_in,
  input  wire logic                    synth_start_in,
  output logic      [FLT_W-1:0]        loop_filter_select_out,
  output logic      [CPI_W-1:0]        charge_pump_out,
  output logic                         external_filter_pin_en_out,
  output logic                         boost_active_out,
  // Ranging
  input  wire logic                    ranging_control_a_start_in,
  input  wire logic                    ranging_control_b_start_in,
  input  wire logic                    vco_too_fast_in,
  output logic                         ranging_start_bit_a_out,
  output logic                         ranging_start_bit_b_out,
  output logic                         ranging_error_bit_out,
  output logic      [RANGE_BAND_W-1:0] vco_band_a_out,
  output logic      [RANGE_BAND_W-1:0] vco_band_b_out,
  output logic      [FREQ_W-1:0]       ranging_freq_out
);
  typedef struct packed {
    logic [FREQ_W-1:0]       freq_a;
    logic [FREQ_W-1:0]       freq_b;
    logic                    out_div;
    logic                    ind_sel;
    logic                    vco_sel;
    logic [REFERENCE_DIVIDER_FIELD_W-1:0]     ref_div;
    logic [FLT_W-1:0]        flt_norm;
    logic [FLT_W-1:0]        flt_boost;
    logic [CPI_W-1:0]        cpi_norm;
    logic [CPI_W-1:0]        cpi_boost;
    logic [BOOST_W-1:0]      boost_dur;
    svrc_rng_state_t         rng;
    logic                    busy_a;
    logic                    busy_b;
    logic                    on_b;
    logic                    err;
    logic [RANGE_BAND_W-1:0] band;
    logic [RANGE_BAND_W-1:0] step;
    logic [7:0]              settle;
    logic [RANGE_BAND_W-1:0] band_a;
    logic [RANGE_BAND_W-1:0] band_b;
  } svrc_state_t;

  svrc_state_t st_r;
  svrc_state_t st_nxt;
  logic        rst_n;
  logic        boost_on;
  logic [1:0]  mode;

  svrc_reset_sync u_rst (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .rst_n_out (rst_n)
  );

  svrc_boost_timer u_boost (
    .clock_in         (clock_in),
    .rst_n_in         (rst_n),
    .start_in         (synth_start_in),
    .duration_in      (st_r.boost_dur),
    .boost_active_out (boost_on)
  );

  always_comb begin
    if (st_r.ind_sel) begin
      mode = VCO_EXT_IND;
    end else if (st_r.vco_sel) begin
      mode = VCO_EXTERNAL;
    end else begin
      mode = VCO_INTERNAL;
    end
  end

  always_comb begin
    st_nxt = st_r;
    if (freq_a_we_in) begin
      st_nxt.freq_a = freq_wdata_in;
    end
    if (freq_b_we_in) begin
      st_nxt.freq_b = freq_wdata_in;
    end
    if (vco_div_we_in) begin
      st_nxt.out_div = output_divider_bit_in;
      st_nxt.ind_sel = inductor_select_bit_in;
      st_nxt.vco_sel = vco_select_bit_in;
      st_nxt.ref_div = reference_divider_field_in;
    end
    if (loop_we_in) begin
      st_nxt.flt_norm  = loop_filter_normal_in;
      st_nxt.flt_boost = loop_filter_boost_in;
      st_nxt.cpi_norm  = charge_pump_normal_in;
      st_nxt.cpi_boost = charge_pump_boost_in;
      st_nxt.boost_dur = boost_duration_in;
    end
    unique case (st_r.rng)
      SVRC_IDLE: begin
        if (ranging_control_a_start_in || ranging_control_b_start_in) begin
          st_nxt.busy_a = ranging_control_a_start_in;
          st_nxt.busy_b = !ranging_control_a_start_in;
          st_nxt.on_b   = !ranging_control_a_start_in;
          st_nxt.band   = BAND_RST;
          st_nxt.step   = BAND_RST >> 1;
          st_nxt.settle = SETTLE_CYC;
          if (mode == VCO_EXTERNAL) begin
            st_nxt.rng = SVRC_DONE;
          end else begin
            st_nxt.rng = SVRC_SETTLE;
          end
        end
      end
      SVRC_SETTLE: begin
        st_nxt.settle = st_r.settle - 8'h01;
        if (st_r.settle == 8'h01) begin
          st_nxt.rng = SVRC_STEP;
        end
      end
      SVRC_STEP: begin
        // Binary search over VCO bands
        if (vco_too_fast_in) begin
          st_nxt.band = st_r.band - st_r.step;
        end else begin
          st_nxt.band = st_r.band + st_r.step;
        end
        st_nxt.step   = st_r.step >> 1;
        st_nxt.settle = SETTLE_CYC;
        if (st_r.step == '0) begin
          st_nxt.band = st_r.band;
          st_nxt.rng  = SVRC_DONE;
        end else begin
          st_nxt.rng = SVRC_SETTLE;
        end
      end
      SVRC_DONE: begin
        // error on edge band or bad mode
        st_nxt.err = (mode == VCO_EXTERNAL) || (st_r.band == '0) || (&st_r.band);
        if (st_r.on_b) begin
          st_nxt.band_b = st_r.band;
        end else begin
          st_nxt.band_a = st_r.band;
        end
        st_nxt.busy_a = 1'b0;
        st_nxt.busy_b = 1'b0;
        st_nxt.rng    = SVRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      st_r          <= '0;
      st_r.freq_a   <= FREQ_RST;
      st_r.freq_b   <= FREQ_RST;
      st_r.ref_div  <= REFERENCE_DIVIDER_FIELD_RST;
      st_r.flt_norm <= FLT_RST;
      st_r.flt_boost <= FLT_RST;
      st_r.cpi_norm <= CPI_RST;
      st_r.cpi_boost <= CPI_RST;
      st_r.rng      <= SVRC_IDLE;
      st_r.band_a   <= BAND_RST;
      st_r.band_b   <= BAND_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign carrier_freq_set_a_out      = st_r.freq_a;
  assign carrier_freq_set_b_out      = st_r.freq_b;
  assign output_divider_bit_out      = st_r.out_div;
  assign reference_divider_field_out = st_r.ref_div;
  assign vco_mode_out                = mode;
  assign loop_filter_select_out      = boost_on ? st_r.flt_boost : st_r.flt_norm;
  assign charge_pump_out             = boost_on ? st_r.cpi_boost : st_r.cpi_norm;
  assign external_filter_pin_en_out  = (loop_filter_select_out == FLT_EXTERNAL);
  assign boost_active_out            = boost_on;
  assign ranging_start_bit_a_out     = st_r.busy_a;
  assign ranging_start_bit_b_out     = st_r.busy_b;
  assign ranging_error_bit_out       = st_r.err;
  assign vco_band_a_out              = st_r.band_a;
  assign vco_band_b_out              = st_r.band_b;
  assign ranging_freq_out            = st_r.on_b ? st_r.freq_b : st_r.freq_a;

  sequence s_start_a;
    st_r.rng == SVRC_IDLE && ranging_control_a_start_in && mode != VCO_EXTERNAL;
  endsequence

  sequence s_start_b;
    st_r.rng == SVRC_IDLE && ranging_control_b_start_in && !ranging_control_a_start_in;
  endsequence

  sequence s_start_ok;
    st_r.rng == SVRC_IDLE && (ranging_control_a_start_in || ranging_control_b_start_in)
      && mode != VCO_EXTERNAL;
  endsequence

  sequence s_start_ext;
    st_r.rng == SVRC_IDLE && (ranging_control_a_start_in || ranging_control_b_start_in)
      && mode == VCO_EXTERNAL;
  endsequence

  a_start_sets_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    s_start_a |=> ranging_start_bit_a_out && !ranging_start_bit_b_out)
    else $error("start A did not set busy A");
  a_start_sets_b: assert property (@(posedge clock_in) disable iff (!rst_n)
    s_start_b |=> ranging_start_bit_b_out && !ranging_start_bit_a_out)
    else $error("start B did not set busy B");
  a_b_uses_set_b: assert property (@(posedge clock_in) disable iff (!rst_n)
    ranging_start_bit_b_out |-> ranging_freq_out == carrier_freq_set_b_out)
    else $error("set B not ranged");
  a_a_uses_set_a: assert property (@(posedge clock_in) disable iff (!rst_n)
    ranging_start_bit_a_out |-> ranging_freq_out == carrier_freq_set_a_out)
    else $error("set A not ranged");
  a_busy_one_hot: assert property (@(posedge clock_in) disable iff (!rst_n)
    !(ranging_start_bit_a_out && ranging_start_bit_b_out))
    else $error("both start bits set");
  a_band_to_b: assert property (@(posedge clock_in) disable iff (!rst_n)
    (st_r.rng == SVRC_DONE && st_r.on_b) |=> vco_band_b_out == $past(st_r.band))
    else $error("band B not stored");
  a_done_clears: assert property (@(posedge clock_in) disable iff (!rst_n)
    st_r.rng == SVRC_DONE |=> !ranging_start_bit_a_out && !ranging_start_bit_b_out)
    else $error("start bit not cleared");
  a_rng_bounded: assert property (@(posedge clock_in) disable iff (!rst_n)
    s_start_a |=> ##[1:900] !ranging_start_bit_a_out)
    else $error("ranging did not finish");
  a_ext_vco_err: assert property (@(posedge clock_in) disable iff (!rst_n)
    s_start_ext |=> ##1 ranging_error_bit_out)
    else $error("external VCO ranging not flagged");
  a_err_stable: assert property (@(posedge clock_in) disable iff (!rst_n)
    st_r.rng != SVRC_DONE |=> $stable(ranging_error_bit_out))
    else $error("error bit moved outside run end");
  a_ext_no_search: assert property (@(posedge clock_in) disable iff (!rst_n)
    s_start_ext |=> st_r.rng == SVRC_DONE)
    else $error("external VCO was searched");
  a_int_searches: assert property (@(posedge clock_in) disable iff (!rst_n)
    s_start_ok |=> st_r.rng == SVRC_SETTLE)
    else $error("internal VCO not searched");
  a_mode_ind: assert property (@(posedge clock_in) disable iff (!rst_n)
    (vco_div_we_in && inductor_select_bit_in) |=> vco_mode_out == VCO_EXT_IND)
    else $error("inductor mode not entered");
  a_mode_ext: assert property (@(posedge clock_in) disable iff (!rst_n)
    (vco_div_we_in && !inductor_select_bit_in && vco_select_bit_in)
      |=> vco_mode_out == VCO_EXTERNAL)
    else $error("external VCO mode not entered");
  a_bypass_pin: assert property (@(posedge clock_in) disable iff (!rst_n)
    external_filter_pin_en_out == (loop_filter_select_out == 2'h0))
    else $error("bypass pin mismatch");
  a_freq_store: assert property (@(posedge clock_in) disable iff (!rst_n)
    freq_a_we_in |=> carrier_freq_set_a_out == $past(freq_wdata_in))
    else $error("frequency A not stored");
  a_boost_sel: assert property (@(posedge clock_in) disable iff (!rst_n)
    boost_on |-> charge_pump_out == st_r.cpi_boost)
    else $error("boost pump not applied");
  a_normal_sel: assert property (@(posedge clock_in) disable iff (!rst_n)
    !boost_on |-> loop_filter_select_out == st_r.flt_norm
      && charge_pump_out == st_r.cpi_norm)
    else $error("normal settings not applied");
endmodule // svrc_ctrl

// [design/svrc_pkg.sv]
package svrc_pkg;

  // Field widths
  localparam int FREQ_W   = 32;
  localparam int FLT_W    = 2;
  localparam int CPI_W    = 8;
  localparam int REFERENCE_DIVIDER_FIELD_W = 2;
  localparam int VSEL_W   = 2;
  localparam int BOOST_W  = 16;

  // Loop filter encodings
  localparam logic [1:0] FLT_EXTERNAL = 2'h0;
  localparam logic [1:0] FLT_BW_X1    = 2'h1;
  localparam logic [1:0] FLT_BW_X2    = 2'h2;
  localparam logic [1:0] FLT_BW_X5    = 2'h3;

  // VCO mode encodings
  localparam logic [1:0] VCO_INTERNAL = 2'h0;
  localparam logic [1:0] VCO_EXT_IND  = 2'h1;
  localparam logic [1:0] VCO_EXTERNAL = 2'h2;

  // Reset values
  localparam logic [31:0] FREQ_RST    = 32'h0;
  localparam logic [1:0]  FLT_RST     = FLT_BW_X1;
  localparam logic [7:0]  CPI_RST     = 8'h08;
  localparam logic [1:0]  REFERENCE_DIVIDER_FIELD_RST  = 2'h0;

  // Ranging search: binary search over VCO bands, band step halves per trial, settle per step
  localparam int          RANGE_BAND_W     = 4;
  localparam int          SETTLE_NS        = 1000;
  localparam int          CLK_PERIOD_NS    = 5;
  localparam int          SETTLE_CYC_INT   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  SETTLE_CYC       = 8'(SETTLE_CYC_INT);
  localparam logic [3:0]  BAND_RST         = 4'h8;

  typedef enum logic [1:0] {
    SVRC_IDLE   = 2'b00,
    SVRC_SETTLE = 2'b01,
    SVRC_STEP   = 2'b10,
    SVRC_DONE   = 2'b11
  } svrc_rng_state_t;

endpackage

// [design/svrc_reset_sync.sv]
`timescale 1ns/1ps
module svrc_reset_sync (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic arst_n_in,
  // Released reset
  output logic      rst_n_out
);
  logic [1:0] sync_r;

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_r <= 2'h0;
    end else begin
      sync_r <= {sync_r[0], 1'b1};
    end
  end

  assign rst_n_out = sync_r[1];
endmodule // svrc_reset_sync

// [verif/svrc_tb.sv]
`timescale 1ns/1ps
module testbench;
  import svrc_pkg::*;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic freq_a_we_in = 1'b0, freq_b_we_in = 1'b0, vco_div_we_in = 1'b0, loop_we_in = 1'b0;
  logic output_divider_bit_in = 1'b0, inductor_select_bit_in = 1'b0, vco_select_bit_in = 1'b0;
  logic synth_start_in = 1'b0, vco_too_fast_in = 1'b0;
  logic ranging_control_a_start_in = 1'b0, ranging_control_b_start_in = 1'b0;
  logic [FREQ_W-1:0] freq_wdata_in = '0;
  logic [REFERENCE_DIVIDER_FIELD_W-1:0] reference_divider_field_in = '0;
  logic [FLT_W-1:0] loop_filter_normal_in = '0, loop_filter_boost_in = '0;
  logic [CPI_W-1:0] charge_pump_normal_in = '0, charge_pump_boost_in = '0;
  logic [BOOST_W-1:0] boost_duration_in = '0;
  logic [FREQ_W-1:0] fa, fb, rf;
  logic od, ep, ba, sa, sb, er;
  logic [REFERENCE_DIVIDER_FIELD_W-1:0] rd;
  logic [VSEL_W-1:0] vm;
  logic [FLT_W-1:0] fl;
  logic [CPI_W-1:0] cp;
  logic [RANGE_BAND_W-1:0] bda, bdb;
  int num_errors = 0;
  int n_compared = 0;

  always #2.5 clock_in = ~clock_in;

  svrc_ctrl u_dut (
    .clock_in(clock_in), .arst_n_in(arst_n_in),
    .freq_a_we_in(freq_a_we_in), .freq_b_we_in(freq_b_we_in), .freq_wdata_in(freq_wdata_in),
    .carrier_freq_set_a_out(fa), .carrier_freq_set_b_out(fb),
    .vco_div_we_in(vco_div_we_in), .output_divider_bit_in(output_divider_bit_in),
    .inductor_select_bit_in(inductor_select_bit_in), .vco_select_bit_in(vco_select_bit_in),
    .reference_divider_field_in(reference_divider_field_in),
    .output_divider_bit_out(od), .reference_divider_field_out(rd), .vco_mode_out(vm),
    .loop_we_in(loop_we_in), .loop_filter_normal_in(loop_filter_normal_in),
    .loop_filter_boost_in(loop_filter_boost_in), .charge_pump_normal_in(charge_pump_normal_in),
    .charge_pump_boost_in(charge_pump_boost_in), .boost_duration_in(boost_duration_in),
    .synth_start_in(synth_start_in), .loop_filter_select_out(fl), .charge_pump_out(cp),
    .external_filter_pin_en_out(ep), .boost_active_out(ba),
    .ranging_control_a_start_in(ranging_control_a_start_in),
    .ranging_control_b_start_in(ranging_control_b_start_in), .vco_too_fast_in(vco_too_fast_in),
    .ranging_start_bit_a_out(sa), .ranging_start_bit_b_out(sb), .ranging_error_bit_out(er),
    .vco_band_a_out(bda), .vco_band_b_out(bdb), .ranging_freq_out(rf)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic set_vco(input logic o, input logic i, input logic s, input logic [1:0] r);
    {output_divider_bit_in, inductor_select_bit_in, vco_select_bit_in} = {o, i, s};
    reference_divider_field_in = r;
    vco_div_we_in = 1'b1;
    tick(1);
    vco_div_we_in = 1'b0;
    tick(1);
  endtask

  task automatic set_loop(input logic [1:0] fn, input logic [1:0] fbst, input logic [7:0] cn,
                          input logic [7:0] cb, input logic [15:0] d);
    {loop_filter_normal_in, loop_filter_boost_in} = {fn, fbst};
    {charge_pump_normal_in, charge_pump_boost_in, boost_duration_in} = {cn, cb, d};
    loop_we_in = 1'b1;
    tick(1);
    loop_we_in = 1'b0;
    tick(1);
  endtask

  task automatic rng_run(input logic b, input int lim);
    int i;
    i = 0;
    {ranging_control_b_start_in, ranging_control_a_start_in} = b ? 2'b10 : 2'b01;
    tick(1);
    {ranging_control_b_start_in, ranging_control_a_start_in} = 2'b00;
    chk({30'h0, sb, sa}, b ? 32'h2 : 32'h1, "busy bit");
    chk(rf, b ? 32'h33a2_9f40 : 32'h19dd_2f01, "ranged set");
    while ((sa | sb) !== 1'b0 && i < lim) begin
      if (i == 3 && !b) ranging_control_b_start_in = 1'b1;
      if (i == 4) ranging_control_b_start_in = 1'b0;
      if (i == 5 && !b) chk({31'h0, sb}, 32'h0, "start while busy");
      tick(1);
      i++;
    end
    chk({31'h0, sa | sb}, 32'h0, "ranging end");
  endtask

  task automatic test_reset();
    chk({fa, fb} == 64'h0, 1'b1, "freq reset");
    chk({fl, cp}, {FLT_RST, CPI_RST}, "loop reset");
    chk({ba, sa, sb, er, ep}, 5'h0, "flag reset");
    chk({bda, bdb, vm}, {BAND_RST, BAND_RST, VCO_INTERNAL}, "band reset");
    $display("test reset done");
  endtask

  task automatic test_freq();
    freq_wdata_in = 32'h19dd_2f01;
    freq_a_we_in = 1'b1;
    tick(1);
    {freq_a_we_in, freq_b_we_in, freq_wdata_in} = {2'b01, 32'h33a2_9f40};
    tick(1);
    freq_b_we_in = 1'b0;
    chk(fa, 32'h19dd_2f01, "set a");
    tick(1);
    chk(fb, 32'h33a2_9f40, "set b");
    $display("test freq done");
  endtask

  task automatic test_vco();
    logic [1:0] ex [4] = '{VCO_INTERNAL, VCO_EXTERNAL, VCO_EXT_IND, VCO_EXT_IND};
    for (int k = 0; k < 4; k++) begin
      set_vco(k[0], k[1], k[0], 2'(3 - k));
      chk(vm, ex[k], "vco mode");
      chk({od, rd}, {k[0], 2'(3 - k)}, "dividers");
    end
    $display("test vco done");
  endtask

  task automatic test_loop();
    int n;
    for (int k = 0; k < 4; k++) begin
      set_loop(2'(k), ~2'(k), 8'h10 + 8'(k), 8'hc0, 16'h0);
      tick(1);
      chk({fl, cp}, {2'(k), 8'h10 + 8'(k)}, "normal loop");
      chk({31'h0, ep}, {31'h0, k == 0}, "external pin");
    end
    set_loop(FLT_BW_X1, FLT_BW_X5, 8'h20, 8'he7, 16'h0006);
    synth_start_in = 1'b1;
    tick(1);
    synth_start_in = 1'b0;
    n = 0;
    for (int k = 0; k < 12; k++) begin
      if (ba === 1'b1) begin
        n++;
        chk({fl, cp}, {FLT_BW_X5, 8'he7}, "boost values");
      end else chk({fl, cp}, {FLT_BW_X1, 8'h20}, "normal values");
      tick(1);
    end
    chk(n, 6, "boost length");
    set_loop(FLT_EXTERNAL, FLT_BW_X2, 8'h01, 8'h02, 16'h0);
    synth_start_in = 1'b1;
    tick(1);
    synth_start_in = 1'b0;
    tick(1);
    chk({ba, ep, fl}, {2'b01, FLT_EXTERNAL}, "no boost");
    $display("test loop done");
  endtask

  task automatic test_ranging();
    set_vco(1'b0, 1'b0, 1'b1, 2'h0);
    rng_run(1'b0, 10);
    chk({31'h0, er}, 32'h1, "external vco error");
    set_vco(1'b0, 1'b0, 1'b0, 2'h1);
    vco_too_fast_in = 1'b1;
    rng_run(1'b0, 1000);
    chk({bda, bdb, er}, {4'h1, BAND_RST, 1'b0}, "set a result");
    set_vco(1'b1, 1'b1, 1'b0, 2'h2);
    vco_too_fast_in = 1'b0;
    rng_run(1'b1, 1000);
    chk({bda, bdb, er}, {4'h1, 4'hf, 1'b1}, "set b result");
    $display("test ranging done");
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    tick(2);
    arst_n_in = 1'b1;
    tick(3);
    test_reset();
    test_freq();
    test_vco();
    test_loop();
    test_ranging();
    test_done();
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
endmodule // testbench
